/* File: core/dmab_buf.sv */
// two-entry skid buffer for issued transfer addresses
`timescale 1ns/10ps
module dmab_buf #(
	parameter int W = 24
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic         skid_v_r;
	logic [W-1:0] skid_r;

	assign in_ready = ~skid_v_r;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
			skid_v_r  <= 1'b0;
			skid_r    <= '0;
		end else if (~out_valid || out_ready) begin
			if (skid_v_r) begin
				out_data  <= skid_r;
				out_valid <= 1'b1;
				skid_v_r  <= 1'b0;
			end else begin
				out_data  <= in_data;
				out_valid <= in_valid;
			end
		end else if (in_valid && ~skid_v_r) begin
			skid_r   <= in_data;
			skid_v_r <= 1'b1;
		end
	end
endmodule

/* File: core/dmab_pkg.sv */
// constants, register map and types of the channel 1b activation block
package dmab_pkg;

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_IO_ADDRESS_1B    = 16'hfefc;
	localparam logic [15:0] IDX_TRANSFER_COUNT   = 16'hfefe;
	localparam logic [15:0] IDX_CHANNEL_CONTROL  = 16'hff00;
	localparam logic [15:0] IDX_BAND_CONTROL     = 16'hff02;
	localparam logic [15:0] IDX_TRANSFER_CONTROL = 16'hff04;
	localparam logic [15:0] IDX_WRITE_GUARD      = 16'hff06;
	localparam logic [15:0] IDX_MODE_SELECT      = 16'hff08;
	localparam logic [15:0] IDX_MEMORY_ADDRESS_B = 16'hff0a;
	localparam logic [15:0] IDX_STATUS           = 16'hff0c;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [15:0] RST_IO_ADDRESS   = 16'h0000;
	localparam logic [15:0] RST_COUNT        = 16'h0000;
	localparam logic [7:0]  RST_CH_CONTROL   = 8'h00;
	localparam logic [15:0] RST_BAND_CONTROL = 16'h0000;
	localparam logic [7:0]  RST_XFER_CONTROL = 8'h00;
	localparam logic        RST_GUARD        = 1'b0;
	localparam logic [2:0]  RST_MODE         = 3'h0;
	localparam logic [23:0] RST_MEM_ADDRESS  = 24'h00_0000;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIT_DEST_DIR      = 7;
	localparam int BIT_DEST_STEP     = 6;
	localparam int BIT_XFER_ENABLE   = 5;
	localparam int BIT_BAND_GUARD_HI = 11;
	localparam int BIT_BAND_GUARD_MD = 7;
	localparam int BIT_BAND_GUARD_LO = 3;
	localparam logic [15:0] BAND_GUARD_MASK = 16'h0888;

	////////////////////////////////////////////////////////////////////////
	// operating modes held in the mode select register
	localparam logic [2:0] MODE_SEQUENTIAL = 3'h0;
	localparam logic [2:0] MODE_IDLE       = 3'h1;
	localparam logic [2:0] MODE_REPEAT     = 3'h2;
	localparam logic [2:0] MODE_NORMAL     = 3'h3;
	localparam logic [2:0] MODE_BLOCK      = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// activation select codes
	localparam logic [3:0] ACT_NONE      = 4'h0;
	localparam logic [3:0] ACT_ADC_END   = 4'h1;
	localparam logic [3:0] ACT_PIN_EDGE  = 4'h2;
	localparam logic [3:0] ACT_PIN_LEVEL = 4'h3;
	localparam logic [3:0] ACT_SER0_TXE  = 4'h4;
	localparam logic [3:0] ACT_SER0_RXF  = 4'h5;
	localparam logic [3:0] ACT_SER1_TXE  = 4'h6;
	localparam logic [3:0] ACT_SER1_RXF  = 4'h7;
	localparam logic [3:0] ACT_TIMER0    = 4'h8;
	localparam logic [3:0] ACT_TIMER5    = 4'hd;

	localparam int ADDR_W = 24;
	localparam int TIMERS = 6;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_STEAL = 3'b100
	} dmab_state_t;

endpackage

/* File: core/dmab_src.sv */
// activation source selector with pin synchroniser and request latch
`timescale 1ns/10ps
module dmab_src (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       sys_rst,
	// request sources
	input  wire logic                       ext_req_pin_n,
	input  wire logic                       adc_done_irq,
	input  wire logic [1:0]                 serial_txe_irq,
	input  wire logic [1:0]                 serial_rxf_irq,
	input  wire logic [dmab_pkg::TIMERS-1:0] timer_irq,
	// engine side
	dmab_src_if.selector                    src
);
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_d_r;
	logic pend_r;
	logic pend_nxt;
	logic fall;
	logic hit;
	logic edge_kind;
	logic level_req;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser; the second stage and its delayed copy are looked at
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			pin_d_r  <= 1'b1;
		end else begin
			pin_s1_r <= ext_req_pin_n;
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end
	assign fall = pin_d_r & ~pin_s2_r;

	////////////////////////////////////////////////////////////////////////
	// source decode
	always_comb begin
		hit            = 1'b0;
		edge_kind      = 1'b1;
		level_req      = 1'b0;
		src.auto_steal = 1'b0;
		case (src.code)
			dmab_pkg::ACT_ADC_END:   hit = src.block & adc_done_irq;
			dmab_pkg::ACT_PIN_EDGE:  hit = fall;
			dmab_pkg::ACT_PIN_LEVEL: begin
				edge_kind = 1'b0;
				level_req = ~pin_s2_r;
			end
			dmab_pkg::ACT_SER0_TXE:  hit = src.block & serial_txe_irq[0];
			dmab_pkg::ACT_SER0_RXF:  hit = src.block & serial_rxf_irq[0];
			dmab_pkg::ACT_SER1_TXE: begin
				if (src.block) begin
					hit = serial_txe_irq[1];
				end else begin
					edge_kind      = 1'b0;
					level_req      = 1'b1;
					src.auto_steal = 1'b1;
				end
			end
			dmab_pkg::ACT_SER1_RXF: begin
				if (src.block) begin
					hit = serial_rxf_irq[1];
				end else begin
					edge_kind = 1'b0;
					level_req = 1'b1;
				end
			end
			default: begin
				if (src.code >= dmab_pkg::ACT_TIMER0 &&
				    src.code <= dmab_pkg::ACT_TIMER5) begin
					hit = src.block &
					      timer_irq[src.code[2:0]];
				end else begin
					edge_kind = 1'b0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// latched request; a new event wins over the take
	always_comb begin
		pend_nxt = pend_r;
		if (src.take) begin
			pend_nxt = 1'b0;
		end
		if (hit) begin
			pend_nxt = 1'b1;
		end
		if (~edge_kind) begin
			pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	assign src.req = edge_kind ? pend_r : level_req;
endmodule

/* File: core/dmab_src_if.sv */
// link between the transfer engine and the activation source selector
`timescale 1ns/10ps
interface dmab_src_if;
	logic [3:0] code;
	logic       block;
	logic       take;
	logic       req;
	logic       auto_steal;

	modport engine   (output code, output block, output take,
	                  input req, input auto_steal);
	modport selector (input code, input block, input take,
	                  output req, output auto_steal);
endinterface

/* File: core/dmab_top.sv */
// channel 1b register file, activation and transfer count engine
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module dmab_top (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        sys_rst,
	// wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [17:0]                 wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic [31:0]                      wb_dat_o,
	output logic                             wb_ack_o,
	// activation sources
	input  wire logic                        external_transfer_request_pin_n,
	input  wire logic                        adc_done_irq,
	input  wire logic [1:0]                  serial_comm_unit_txe_irq,
	input  wire logic [1:0]                  serial_comm_unit_rxf_irq,
	input  wire logic [dmab_pkg::TIMERS-1:0]  pulse_timer_unit_irq,
	// issued transfers
	output logic                             xfer_valid,
	input  wire logic                        xfer_ready,
	output logic [dmab_pkg::ADDR_W-1:0]      xfer_addr
);

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0]                 io_address_channel_1b_r;
	logic [15:0]                 transfer_count_channel_1b_r;
	logic [15:0]                 transfer_count_channel_1b_nxt;
	logic [7:0]                  channel_b_control_full_address_r;
	logic [15:0]                 band_control_r;
	logic [7:0]                  transfer_control_r;
	logic [7:0]                  transfer_control_nxt;
	logic                        write_guard_r;
	logic [2:0]                  mode_r;
	logic [dmab_pkg::ADDR_W-1:0] memory_address_b_r;
	logic [dmab_pkg::ADDR_W-1:0] memory_address_b_nxt;
	dmab_pkg::dmab_state_t       state_r;
	dmab_pkg::dmab_state_t       state_nxt;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic        bus_req;
	logic        wr_go;
	logic [15:0] idx;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic [31:0] rd_nxt;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_go   = bus_req & wb_we_i;
	assign idx     = wb_adr_i[17:2];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign wmask[8*g+7:8*g] = {8{wb_sel_i[g]}};
		end
	endgenerate

	assign wdat = wb_dat_i & wmask;

	////////////////////////////////////////////////////////////////////////
	// engine signals
	dmab_src_if  src ();
	logic        buf_ready;
	logic        issue;
	logic        enabled;
	logic        count_ok;
	logic        last_one;
	logic        is_normal;
	logic        is_repeat;
	logic        is_block;
	logic [7:0]  low_byte;

	assign enabled   = transfer_control_r[dmab_pkg::BIT_XFER_ENABLE];
	assign is_normal = (mode_r == dmab_pkg::MODE_NORMAL);
	assign is_repeat = (mode_r == dmab_pkg::MODE_REPEAT);
	assign is_block  = (mode_r == dmab_pkg::MODE_BLOCK);
	assign low_byte  = transfer_count_channel_1b_r[7:0];

	assign src.code  = channel_b_control_full_address_r[3:0];
	assign src.block = is_block;

	// normal mode never looks at the count; repeat mode never stops on it
	always_comb begin
		count_ok = 1'b0;
		last_one = 1'b0;
		if (is_normal) begin
			count_ok = 1'b1;
		end else if (is_repeat) begin
			count_ok = 1'b1;
		end else begin
			count_ok = (transfer_count_channel_1b_r != 16'h0000);
			last_one = (transfer_count_channel_1b_r == 16'h0001);
		end
	end

	assign issue = (state_r == dmab_pkg::ST_RUN) & enabled & src.req &
	               count_ok & buf_ready;
	assign src.take = issue;

	////////////////////////////////////////////////////////////////////////
	// state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			dmab_pkg::ST_IDLE: begin
				if (enabled) begin
					state_nxt = dmab_pkg::ST_RUN;
				end
			end
			dmab_pkg::ST_RUN: begin
				if (~enabled) begin
					state_nxt = dmab_pkg::ST_IDLE;
				end else if (issue && src.auto_steal) begin
					state_nxt = dmab_pkg::ST_STEAL;
				end
			end
			dmab_pkg::ST_STEAL: begin
				state_nxt = enabled ? dmab_pkg::ST_RUN : dmab_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = dmab_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= dmab_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer counter; a bus write wins over the engine's step
	always_comb begin
		transfer_count_channel_1b_nxt = transfer_count_channel_1b_r;
		if (issue && !is_normal) begin
			if (is_repeat) begin
				if (low_byte <= 8'h01) begin
					transfer_count_channel_1b_nxt[7:0] =
						transfer_count_channel_1b_r[15:8];
				end else begin
					transfer_count_channel_1b_nxt[7:0] = low_byte - 8'h01;
				end
			end else begin
				transfer_count_channel_1b_nxt =
					transfer_count_channel_1b_r - 16'h0001;
			end
		end
		if (wr_go && idx == dmab_pkg::IDX_TRANSFER_COUNT) begin
			transfer_count_channel_1b_nxt =
				(transfer_count_channel_1b_r & ~wmask[15:0]) | wdat[15:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			transfer_count_channel_1b_r <= dmab_pkg::RST_COUNT;
		end else begin
			transfer_count_channel_1b_r <= transfer_count_channel_1b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// destination address stepping
	always_comb begin
		memory_address_b_nxt = memory_address_b_r;
		if (issue &&
		    channel_b_control_full_address_r[dmab_pkg::BIT_DEST_STEP]) begin
			if (channel_b_control_full_address_r[dmab_pkg::BIT_DEST_DIR]) begin
				memory_address_b_nxt = memory_address_b_r - 24'h00_0001;
			end else begin
				memory_address_b_nxt = memory_address_b_r + 24'h00_0001;
			end
		end
		if (wr_go && idx == dmab_pkg::IDX_MEMORY_ADDRESS_B) begin
			memory_address_b_nxt =
				(memory_address_b_r & ~wmask[23:0]) | wdat[23:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			memory_address_b_r <= dmab_pkg::RST_MEM_ADDRESS;
		end else begin
			memory_address_b_r <= memory_address_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer control; the enable drops when the count runs out
	always_comb begin
		transfer_control_nxt = transfer_control_r;
		if (issue && last_one) begin
			transfer_control_nxt[dmab_pkg::BIT_XFER_ENABLE] = 1'b0;
		end
		if (wr_go && idx == dmab_pkg::IDX_TRANSFER_CONTROL && wb_sel_i[0]) begin
			transfer_control_nxt = {transfer_control_nxt[7:6],
			                        transfer_control_nxt[5],
			                        wdat[4:0]};
			transfer_control_nxt[7:6] = wdat[7:6];
			if (write_guard_r) begin
				transfer_control_nxt[dmab_pkg::BIT_XFER_ENABLE] =
					wdat[dmab_pkg::BIT_XFER_ENABLE];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			transfer_control_r <= dmab_pkg::RST_XFER_CONTROL;
		end else begin
			transfer_control_r <= transfer_control_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// guarded channel control and band control
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			channel_b_control_full_address_r <= dmab_pkg::RST_CH_CONTROL;
		end else if (wr_go && idx == dmab_pkg::IDX_CHANNEL_CONTROL &&
		             wb_sel_i[0] && write_guard_r) begin
			channel_b_control_full_address_r <= wdat[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			band_control_r <= dmab_pkg::RST_BAND_CONTROL;
		end else if (wr_go && idx == dmab_pkg::IDX_BAND_CONTROL) begin
			if (write_guard_r) begin
				band_control_r <= (band_control_r & ~wmask[15:0]) |
				                  wdat[15:0];
			end else begin
				band_control_r <= (band_control_r &
				                   ~(wmask[15:0] & ~dmab_pkg::BAND_GUARD_MASK)) |
				                  (wdat[15:0] & ~dmab_pkg::BAND_GUARD_MASK);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// plain registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			write_guard_r <= dmab_pkg::RST_GUARD;
		end else if (wr_go && idx == dmab_pkg::IDX_WRITE_GUARD && wb_sel_i[0]) begin
			write_guard_r <= wdat[0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_r <= dmab_pkg::RST_MODE;
		end else if (wr_go && idx == dmab_pkg::IDX_MODE_SELECT && wb_sel_i[0]) begin
			mode_r <= wdat[2:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			io_address_channel_1b_r <= dmab_pkg::RST_IO_ADDRESS;
		end else if (wr_go && idx == dmab_pkg::IDX_IO_ADDRESS_1B) begin
			io_address_channel_1b_r <= (io_address_channel_1b_r &
			                            ~wmask[15:0]) | wdat[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux and acknowledge; unmapped reads return zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (idx == dmab_pkg::IDX_IO_ADDRESS_1B) begin
			rd_nxt[15:0] = io_address_channel_1b_r;
		end else if (idx == dmab_pkg::IDX_TRANSFER_COUNT) begin
			rd_nxt[15:0] = transfer_count_channel_1b_r;
		end else if (idx == dmab_pkg::IDX_CHANNEL_CONTROL) begin
			rd_nxt[7:0] = channel_b_control_full_address_r;
		end else if (idx == dmab_pkg::IDX_BAND_CONTROL) begin
			rd_nxt[15:0] = band_control_r;
		end else if (idx == dmab_pkg::IDX_TRANSFER_CONTROL) begin
			rd_nxt[7:0] = transfer_control_r;
		end else if (idx == dmab_pkg::IDX_WRITE_GUARD) begin
			rd_nxt[0] = write_guard_r;
		end else if (idx == dmab_pkg::IDX_MODE_SELECT) begin
			rd_nxt[2:0] = mode_r;
		end else if (idx == dmab_pkg::IDX_MEMORY_ADDRESS_B) begin
			rd_nxt[23:0] = memory_address_b_r;
		end else if (idx == dmab_pkg::IDX_STATUS) begin
			rd_nxt[3:0] = {src.req, ~buf_ready,
			               (state_r == dmab_pkg::ST_STEAL),
			               (state_r != dmab_pkg::ST_IDLE)};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_nxt : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// submodules
	dmab_src u_src (
		.ref_clk        (ref_clk),
		.sys_rst        (sys_rst),
		.ext_req_pin_n  (external_transfer_request_pin_n),
		.adc_done_irq   (adc_done_irq),
		.serial_txe_irq (serial_comm_unit_txe_irq),
		.serial_rxf_irq (serial_comm_unit_rxf_irq),
		.timer_irq      (pulse_timer_unit_irq),
		.src            (src)
	);

	dmab_buf #(
		.W (dmab_pkg::ADDR_W)
	) u_buf (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.in_valid  (issue),
		.in_ready  (buf_ready),
		.in_data   (memory_address_b_r),
		.out_valid (xfer_valid),
		.out_ready (xfer_ready),
		.out_data  (xfer_addr)
	);

endmodule

/* File: testbench/dmab_asserts.sv */
// port assertions of the channel 1b activation block
`timescale 1ns/10ps
module dmab_asserts (
	// clock and reset
	input wire logic                        ref_clk,
	input wire logic                        sys_rst,
	// register bus
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [17:0]                 wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	// issued transfers
	input wire logic                        xfer_valid,
	input wire logic                        xfer_ready,
	input wire logic [dmab_pkg::ADDR_W-1:0] xfer_addr
);
	default clocking @(posedge ref_clk); endclocking
	////////////////////////////////////////////////////////////////////////
	// mirror of software-owned fields, updated at the acknowledged edge
	logic        guard_r;
	logic [7:0]  ctl_r;
	logic [2:0]  mode_r;
	logic [15:0] idx;
	logic        wr;
	logic        none_c;
	logic        irq_c;
	assign idx = wb_adr_i[17:2];
	assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	assign none_c = ctl_r[3:0] == 4'h0 || ctl_r[3:0] > 4'hd;
	assign irq_c = mode_r == dmab_pkg::MODE_NORMAL && (ctl_r[3:0] == 4'h1
		|| ctl_r[3:0] inside {[4'h4:4'h5], [4'h8:4'hd]});
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			guard_r <= dmab_pkg::RST_GUARD;
			ctl_r   <= dmab_pkg::RST_CH_CONTROL;
			mode_r  <= dmab_pkg::RST_MODE;
		end else if (wr) begin
			if (idx == dmab_pkg::IDX_WRITE_GUARD)
				guard_r <= wb_dat_i[0];
			if (idx == dmab_pkg::IDX_CHANNEL_CONTROL && guard_r)
				ctl_r <= wb_dat_i[7:0];
			if (idx == dmab_pkg::IDX_MODE_SELECT)
				mode_r <= wb_dat_i[2:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence taken_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd_ctl_s;
		taken_s ##0 !wb_we_i && idx == dmab_pkg::IDX_CHANNEL_CONTROL ##1 wb_ack_o;
	endsequence
	sequence rd_hole_s;
		taken_s ##0 !wb_we_i && (idx < dmab_pkg::IDX_IO_ADDRESS_1B
			|| idx > dmab_pkg::IDX_STATUS || idx[0]) ##1 wb_ack_o;
	endsequence
	sequence stall_s;
		xfer_valid && !xfer_ready;
	endsequence
	ack_after_req_a: assert property (disable iff (sys_rst)
		taken_s |=> wb_ack_o) else $error("bus request not answered");
	ack_single_a: assert property (disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	dat_idle_a: assert property (disable iff (sys_rst)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("stray read data");
	rd_hole_a: assert property (disable iff (sys_rst)
		rd_hole_s |-> wb_dat_o == 32'h0000_0000) else $error("hole read nonzero");
	ctl_guard_a: assert property (disable iff (sys_rst)
		rd_ctl_s |-> wb_dat_o == {24'h00_0000, ctl_r})
		else $error("control readback differs");
	xfer_hold_a: assert property (disable iff (sys_rst)
		stall_s |=> xfer_valid && $stable(xfer_addr))
		else $error("stalled transfer changed");
	no_source_a: assert property (disable iff (sys_rst)
		none_c && $stable(ctl_r) && !xfer_valid |=> !xfer_valid)
		else $error("transfer with no source");
	normal_irq_a: assert property (disable iff (sys_rst)
		irq_c && $stable({mode_r, ctl_r}) && !xfer_valid |=> !xfer_valid)
		else $error("interrupt code started normal mode");
endmodule

/* File: testbench/dmab_periph_model.sv */
// peripheral interrupts and external request pin seen by the channel
`timescale 1ns/10ps
module dmab_periph_model (
	// clock and command
	input wire logic       ref_clk,
	input wire logic       go,
	input wire logic       hold,
	input wire logic [3:0] kind,
	// request lines
	output logic           pin_n,
	output logic           adc,
	output logic [1:0]     txe,
	output logic [1:0]     rxf,
	output logic [5:0]     tmr
);
	logic all;
	// kinds 1110 and 1111 fire every source at once
	assign all = go && kind[3:1] == 3'b111;
	initial begin
		pin_n = 1'b1;
		adc = 1'b0;
		txe = 2'h0;
		rxf = 2'h0;
		tmr = 6'h00;
	end
	always @(posedge ref_clk) begin
		adc <= all || go && kind == 4'h1;
		txe <= {2{all}} | {go && kind == 4'h6, go && kind == 4'h4};
		rxf <= {2{all}} | {go && kind == 4'h7, go && kind == 4'h5};
		tmr <= {6{all}} | (go && kind[3] ? 6'h01 << kind[2:0] : 6'h00);
		pin_n <= !(all || hold || go && kind[3:1] == 3'b001);
	end
endmodule

/* File: testbench/tb_dma_channel_b_activation_control.sv */
// self-checking bench of the channel 1b activation block
`timescale 1ns/10ps
module tb_dma_channel_b_activation_control;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic [17:0] adr = 18'h0_0000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        go = 1'b0;
	logic        hold = 1'b0;
	logic [3:0]  kind = 4'h0;
	logic        pin_n;
	logic        adc;
	logic [1:0]  txe;
	logic [1:0]  rxf;
	logic [5:0]  tmr;
	logic        xv;
	logic        xr = 1'b0;
	logic [23:0] xa;
	logic [23:0] exp_addr = 24'h00_0000;
	logic [23:0] step = 24'h00_0000;
	logic [31:0] q;
	int          got_n = 0;
	int          fail_count = 0;
	int          check_count = 0;
	int          seed = 32'hb848_beb0;
	always #2 ref_clk = ~ref_clk;
	dmab_top uut (.ref_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack),
		.external_transfer_request_pin_n(pin_n), .adc_done_irq(adc),
		.serial_comm_unit_txe_irq(txe), .serial_comm_unit_rxf_irq(rxf),
		.pulse_timer_unit_irq(tmr), .xfer_valid(xv), .xfer_ready(xr),
		.xfer_addr(xa));
	dmab_periph_model peri (.ref_clk, .go, .hold, .kind, .pin_n, .adc,
		.txe, .rxf, .tmr);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("BAD at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= {i, 2'b00};
		wdat <= d;
		@(posedge ref_clk);
		while (ack !== 1'b1)
			@(posedge ref_clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdc(input logic [15:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0000_0000);
		chk(q, e);
	endtask
	function automatic logic [23:0] step_of(input logic [7:0] c);
		if (!c[6])
			return 24'h00_0000;
		return c[7] ? 24'hff_ffff : 24'h00_0001;
	endfunction
	// receiver stalls at random; every accepted address is checked
	always @(posedge ref_clk) begin
		xr <= ($random(seed) & 3) != 0;
		if (xv === 1'b1 && xr === 1'b1) begin
			chk({8'h00, xa}, {8'h00, exp_addr});
			exp_addr = exp_addr + step;
			got_n++;
		end
	end
	// configure, enable, fire the source kind k and count the transfers
	task automatic run(input logic [2:0] m, input logic [7:0] c,
		input logic [15:0] n, input logic [3:0] k, input int want);
		int i = 0;
		exp_addr = 24'($random(seed));
		step = step_of(c);
		bus(1'b1, dmab_pkg::IDX_MODE_SELECT, {29'h0, m});
		bus(1'b1, dmab_pkg::IDX_CHANNEL_CONTROL, {24'h0, c});
		bus(1'b1, dmab_pkg::IDX_TRANSFER_COUNT, {16'h0, n});
		bus(1'b1, dmab_pkg::IDX_MEMORY_ADDRESS_B, {8'h0, exp_addr});
		got_n = 0;
		bus(1'b1, dmab_pkg::IDX_TRANSFER_CONTROL, 32'h0000_0020);
		kind <= k;
		go <= 1'b1;
		hold <= want < 0 || want > 1;
		@(posedge ref_clk);
		go <= 1'b0;
		while (i < 300 && (want <= 0 || got_n < want)) begin
			@(posedge ref_clk);
			i++;
		end
		hold <= 1'b0;
		bus(1'b1, dmab_pkg::IDX_TRANSFER_CONTROL, 32'h0000_0000);
		repeat (20) @(posedge ref_clk);
		if (want >= 0)
			chk(got_n, want);
		else
			chk(32'(got_n > 0), 32'h0000_0001);
		bus(1'b0, dmab_pkg::IDX_TRANSFER_COUNT, 32'h0000_0000);
		$display("run mode %0d ctl %h: %0d transfers", m, c, got_n);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] n;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 10; i++)
			rdc(16'hfefc + 16'(2 * i), 32'h0000_0000);
		bus(1'b1, dmab_pkg::IDX_CHANNEL_CONTROL, 32'h0000_004f);
		rdc(dmab_pkg::IDX_CHANNEL_CONTROL, 32'h0000_0000);
		bus(1'b1, dmab_pkg::IDX_BAND_CONTROL, 32'h0000_ffff);
		rdc(dmab_pkg::IDX_BAND_CONTROL, 32'h0000_f777);
		bus(1'b1, dmab_pkg::IDX_TRANSFER_CONTROL, 32'h0000_00ff);
		rdc(dmab_pkg::IDX_TRANSFER_CONTROL, 32'h0000_00df);
		bus(1'b1, dmab_pkg::IDX_WRITE_GUARD, 32'h0000_0001);
		bus(1'b1, dmab_pkg::IDX_CHANNEL_CONTROL, 32'h0000_008f);
		rdc(dmab_pkg::IDX_CHANNEL_CONTROL, 32'h0000_008f);
		bus(1'b1, dmab_pkg::IDX_BAND_CONTROL, 32'h0000_0000);
		$display("guard test done");
		n = 16'(($random(seed) & 3) + 1);
		run(dmab_pkg::MODE_SEQUENTIAL, 8'h43, n, 4'h3, int'(n));
		chk(q, 32'h0000_0000);
		run(dmab_pkg::MODE_IDLE, 8'hc3, n, 4'h3, int'(n));
		chk(q, 32'h0000_0000);
		run(dmab_pkg::MODE_REPEAT, 8'h43, 16'h0304, 4'h3, -1);
		chk(q, 32'(16'h0303 - (got_n - 1) % 3));
		for (int c = 1; c < 14; c++)
			run(dmab_pkg::MODE_BLOCK, {4'h4, 4'(c)}, 16'h0001, 4'(c), 1);
		run(dmab_pkg::MODE_BLOCK, 8'h40, 16'h0001, 4'hf, 0);
		run(dmab_pkg::MODE_BLOCK, 8'h4e, 16'h0001, 4'hf, 0);
		run(dmab_pkg::MODE_BLOCK, 8'h4f, 16'h0001, 4'hf, 0);
		for (int c = 1; c < 14; c++) begin
			if (c != 3 && c != 6 && c != 7) begin
				run(dmab_pkg::MODE_NORMAL, {4'h4, 4'(c)}, n, 4'hf, int'(c == 2));
				chk(q, {16'h0, n});
			end
		end
		run(dmab_pkg::MODE_NORMAL, 8'hc6, n, 4'h0, -1);
		chk(q, {16'h0, n});
		run(dmab_pkg::MODE_NORMAL, 8'h87, n, 4'h0, -1);
		chk(q, {16'h0, n});
		close_out;
	end
	initial begin
		#(4 * 60000);
		fail_count++;
		close_out;
	end
endmodule
bind dmab_top dmab_asserts chk_i (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.xfer_valid, .xfer_ready, .xfer_addr);
